//--- qbp_ext_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// external circuits on ports 1-3: weak pullup, strong pulldown, outside pull-low
module qbp_ext_model (
   input  wire logic [7:0] port1_pins_pd,
   input  wire logic [7:0] port2_pins_pd,
   input  wire logic [7:0] port3_pins_pd,
   input  wire logic [7:0] pull_low1,
   input  wire logic [7:0] pull_low2,
   input  wire logic [7:0] pull_low3,
   output logic      [7:0] port1_pins_in,
   output logic      [7:0] port2_pins_in,
   output logic      [7:0] port3_pins_in
);
   // weak pullup loses to any low driver, so an undriven line reads high
   assign port1_pins_in = ~(port1_pins_pd | pull_low1);
   assign port2_pins_in = ~(port2_pins_pd | pull_low2);
   assign port3_pins_in = ~(port3_pins_pd | pull_low3);
endmodule : qbp_ext_model

//--- qbp_pin.sv
`timescale 1ns/1ps
// one quasi-bidirectional pin: latch drive, kick pulse, input sync
module qbp_pin
  import qbp_pkg::*;
#(
   parameter int KICK = QBP_KICK_CYC
) (
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic drive,
   input  wire logic pin_in,
   output logic      pull_down,
   output logic      pull_up_strong,
   output logic      level
);
   // counter is four bits wide, so the pulse cannot exceed 15 clocks
   if (KICK < 1 || KICK > 15) begin : g_bad_kick
      $error("qbp_pin: KICK out of range");
   end
   logic       drive_d;
   logic [3:0] kick_cnt;
   logic       sync1;
   always_ff @(posedge mclk) begin
      if (rst) begin
         drive_d <= 1'b1;
         pull_down <= 1'b0;
      end else begin
         drive_d <= drive;
         pull_down <= ~drive;
      end
   end
   // kick only on a 0-to-1 change; weak pullup alone afterwards
   always_ff @(posedge mclk) begin
      if (rst) begin
         kick_cnt <= 4'h0;
         pull_up_strong <= 1'b0;
      end else if (drive && !drive_d) begin
         kick_cnt <= 4'(KICK - 1);
         pull_up_strong <= 1'b1;
      end else if (!drive) begin
         kick_cnt <= 4'h0;
         pull_up_strong <= 1'b0;
      end else if (kick_cnt != 4'h0) begin
         kick_cnt <= kick_cnt - 4'h1;
      end else begin
         pull_up_strong <= 1'b0;
      end
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         sync1 <= 1'b1;
         level <= 1'b1;
      end else begin
         sync1 <= pin_in;
         level <= sync1;
      end
   end
endmodule : qbp_pin

//--- qbp_pkg.sv
package qbp_pkg;
   localparam int          QBP_PORT_W        = 8;
   localparam logic [7:0]  QBP_LATCH_RESET   = 8'hff;
   // strong pull-up pulse length, in nanoseconds, rounded up to core clocks
   localparam int          QBP_KICK_NS       = 50;
   localparam int          QBP_CLK_NS        = 25;
   localparam int          QBP_KICK_CYC      = (QBP_KICK_NS + QBP_CLK_NS - 1) / QBP_CLK_NS;
   localparam logic [3:0]  QBP_KICK_CYC_W    = 4'(QBP_KICK_CYC);
   // port 1 bit positions
   localparam int          QBP_P1_T2IO       = 0;
   localparam int          QBP_P1_T2TRIG     = 1;
   localparam int          QBP_P1_U1RX       = 2;
   localparam int          QBP_P1_U1TX       = 3;
   localparam int          QBP_P1_IRQ2       = 4;
   localparam int          QBP_P1_IRQ3       = 5;
   localparam int          QBP_P1_IRQ4       = 6;
   localparam int          QBP_P1_IRQ5       = 7;
   // port 3 bit positions
   localparam int          QBP_P3_U0RX       = 0;
   localparam int          QBP_P3_U0TX       = 1;
   localparam int          QBP_P3_IRQ0       = 2;
   localparam int          QBP_P3_IRQ1       = 3;
   localparam int          QBP_P3_T0IN       = 4;
   localparam int          QBP_P3_T1IN       = 5;
   localparam int          QBP_P3_WRS        = 6;
   localparam int          QBP_P3_RDS        = 7;
   typedef enum logic [2:0] {
      QBP_BUS_IDLE  = 3'b001,
      QBP_BUS_HIGH  = 3'b010,
      QBP_BUS_PAGE1 = 3'b100
   } qbp_bus_t;
endpackage : qbp_pkg

//--- qbp_ports.sv
`timescale 1ns/1ps
// Function
// R1: reset sets port 1, 2, 3 latches high
// R2: written zero holds strong pulldown on
// R3: zero-to-one write gives brief strong pull-up
// R4: latched one reads the external pin level
// R5: port 1 bits 0-3 timer two, uart1
// R6: port 1 bits 4-7 edge interrupts two-five
// R7: external access drives address high byte on port 2
// R8: page mode 1 puts both bytes on port 2
// R9: port 3 bits 0,1 uart0 rx, tx
// R10: port 3 bits 2,3 interrupts zero, one
// R11: port 3 bits 4,5 timer count inputs
// R12: port 3 bits 6,7 write, read strobes
// R13: select low fetches code externally, high internally
// R14: internal ram access ignores program source select
// R15: alternate output gated by latch bit (AND)
// R16: pin inputs synchronised before any use
module qbp_ports
  import qbp_pkg::*;
(
   input  wire logic               mclk,
   input  wire logic               rst,
   input  wire logic               latch_wr_p1,
   input  wire logic               latch_wr_p2,
   input  wire logic               latch_wr_p3,
   input  wire logic [7:0]         latch_wdata,
   input  wire logic [7:0]         port1_pins_in,
   input  wire logic [7:0]         port2_pins_in,
   input  wire logic [7:0]         port3_pins_in,
   input  wire logic               timer_two_io_out,
   input  wire logic               uart1_tx_out,
   input  wire logic               uart0_tx_out,
   input  wire logic               xdata_wr_strobe_n,
   input  wire logic               xdata_rd_strobe_n,
   input  wire logic               ext_bus_active,
   input  wire logic               page_mode1,
   input  wire logic [15:0]        ext_addr,
   input  wire logic               addr_low_phase,
   input  wire logic               program_source_sel,
   input  wire logic               iram_access_req,
   output logic      [7:0]         port1_pins_pd,
   output logic      [7:0]         port1_pins_pu,
   output logic      [7:0]         port2_pins_pd,
   output logic      [7:0]         port2_pins_pu,
   output logic      [7:0]         port3_pins_pd,
   output logic      [7:0]         port3_pins_pu,
   output logic      [7:0]         port1_read,
   output logic      [7:0]         port2_read,
   output logic      [7:0]         port3_read,
   output logic      [7:0]         latch_p1,
   output logic      [7:0]         latch_p2,
   output logic      [7:0]         latch_p3,
   output logic                    timer_two_io,
   output logic                    timer_two_trigger,
   output logic                    uart1_rx_in,
   output logic                    uart0_rx_in,
   output logic                    ext_irq_two,
   output logic                    ext_irq_three,
   output logic                    ext_irq_four,
   output logic                    ext_irq_five,
   output logic                    ext_irq_zero_lvl,
   output logic                    ext_irq_one,
   output logic                    timer_zero_count_in,
   output logic                    timer_one_count_in,
   output logic                    fetch_external,
   output logic                    iram_access_ok
);
   import qbp_pkg::*;
   ////////////////////////////////////////////////////////////////////////////
   // latches
   always_ff @(posedge mclk) begin
      if (rst) begin
         latch_p1 <= QBP_LATCH_RESET; // R1
         latch_p2 <= QBP_LATCH_RESET; // R1
         latch_p3 <= QBP_LATCH_RESET; // R1
      end else begin
         if (latch_wr_p1) latch_p1 <= latch_wdata; // R2
         if (latch_wr_p2) latch_p2 <= latch_wdata; // R2
         if (latch_wr_p3) latch_p3 <= latch_wdata; // R2
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // effective drive with alternates
   logic [7:0] alt1;
   logic [7:0] alt3;
   logic [7:0] drv1;
   logic [7:0] drv2;
   logic [7:0] drv3;
   always_comb begin
      alt1 = 8'hff; // input functions leave pin released
      alt1[QBP_P1_T2IO] = timer_two_io_out; // R5
      alt1[QBP_P1_U1TX] = uart1_tx_out; // R5
      alt3 = 8'hff;
      alt3[QBP_P3_U0TX] = uart0_tx_out; // R9
      alt3[QBP_P3_WRS]  = xdata_wr_strobe_n; // R12
      alt3[QBP_P3_RDS]  = xdata_rd_strobe_n; // R12
      drv1 = latch_p1 & alt1; // R15
      drv3 = latch_p3 & alt3; // R15
      // address bus overrides latch while the bus owns port 2
      if (ext_bus_active && page_mode1 && addr_low_phase)
         drv2 = ext_addr[7:0]; // R8
      else if (ext_bus_active)
         drv2 = ext_addr[15:8]; // R7
      else
         drv2 = latch_p2;
   end
   ////////////////////////////////////////////////////////////////////////////
   // pin cells
   logic [7:0] lvl1;
   logic [7:0] lvl2;
   logic [7:0] lvl3;
   genvar gi;
   generate
      for (gi = 0; gi < QBP_PORT_W; gi++) begin : g_pin
         qbp_pin u_p1 (.mclk(mclk), .rst(rst), .drive(drv1[gi]), .pin_in(port1_pins_in[gi]),
                       .pull_down(port1_pins_pd[gi]), .pull_up_strong(port1_pins_pu[gi]),
                       .level(lvl1[gi])); // R3 R16
         qbp_pin u_p2 (.mclk(mclk), .rst(rst), .drive(drv2[gi]), .pin_in(port2_pins_in[gi]),
                       .pull_down(port2_pins_pd[gi]), .pull_up_strong(port2_pins_pu[gi]),
                       .level(lvl2[gi])); // R3 R16
         qbp_pin u_p3 (.mclk(mclk), .rst(rst), .drive(drv3[gi]), .pin_in(port3_pins_in[gi]),
                       .pull_down(port3_pins_pd[gi]), .pull_up_strong(port3_pins_pu[gi]),
                       .level(lvl3[gi])); // R3 R16
      end
   endgenerate
   ////////////////////////////////////////////////////////////////////////////
   // input side
   logic [7:0] lvl1_d;
   always_ff @(posedge mclk) begin
      if (rst) begin
         port1_read <= 8'hff;
         port2_read <= 8'hff;
         port3_read <= 8'hff;
         lvl1_d <= 8'hff;
      end else begin
         port1_read <= lvl1; // R4
         port2_read <= lvl2; // R4
         port3_read <= lvl3; // R4
         lvl1_d <= lvl1;
      end
   end
   // edge flags pulse one cycle; edges seen on synchronised levels only
   always_ff @(posedge mclk) begin
      if (rst) begin
         ext_irq_two <= 1'b0;
         ext_irq_three <= 1'b0;
         ext_irq_four <= 1'b0;
         ext_irq_five <= 1'b0;
      end else begin
         ext_irq_two   <= lvl1[QBP_P1_IRQ2] & ~lvl1_d[QBP_P1_IRQ2]; // R6
         ext_irq_three <= ~lvl1[QBP_P1_IRQ3] & lvl1_d[QBP_P1_IRQ3]; // R6
         ext_irq_four  <= lvl1[QBP_P1_IRQ4] & ~lvl1_d[QBP_P1_IRQ4]; // R6
         ext_irq_five  <= ~lvl1[QBP_P1_IRQ5] & lvl1_d[QBP_P1_IRQ5]; // R6
      end
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         timer_two_io <= 1'b1;
         timer_two_trigger <= 1'b1;
         uart1_rx_in <= 1'b1;
         uart0_rx_in <= 1'b1;
         ext_irq_zero_lvl <= 1'b1;
         ext_irq_one <= 1'b1;
         timer_zero_count_in <= 1'b1;
         timer_one_count_in <= 1'b1;
      end else begin
         timer_two_io <= lvl1[QBP_P1_T2IO]; // R5
         timer_two_trigger <= lvl1[QBP_P1_T2TRIG]; // R5
         uart1_rx_in <= lvl1[QBP_P1_U1RX]; // R5
         uart0_rx_in <= lvl3[QBP_P3_U0RX]; // R9
         ext_irq_zero_lvl <= lvl3[QBP_P3_IRQ0]; // R10
         ext_irq_one <= lvl3[QBP_P3_IRQ1]; // R10
         timer_zero_count_in <= lvl3[QBP_P3_T0IN]; // R11
         timer_one_count_in <= lvl3[QBP_P3_T1IN]; // R11
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // program source; strap is a tied level, so sampling each cycle is enough
   always_ff @(posedge mclk) begin
      if (rst) begin
         fetch_external <= 1'b0;
         iram_access_ok <= 1'b0;
      end else begin
         fetch_external <= ~program_source_sel; // R13
         iram_access_ok <= iram_access_req; // R14
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // checks
   localparam int KICK_DLY = QBP_KICK_CYC;
   latch_reset_a: assert property (@(posedge mclk) rst |=> // R1
      {latch_p1, latch_p2, latch_p3} == {3{QBP_LATCH_RESET}})
      else $error("port latches not high after reset");
   hold_low_a: assert property (@(posedge mclk) disable iff (rst)
      !latch_p1[0] |=> port1_pins_pd[0]) // R2
      else $error("pulldown missing on zero");
   kick_a: assert property (@(posedge mclk) disable iff (rst)
      $rose(drv1[0]) |=> port1_pins_pu[0] ##KICK_DLY !port1_pins_pu[0]) // R3
      else $error("strong pull-up length wrong");
   read_a: assert property (@(posedge mclk) disable iff (rst)
      1'b1 |-> port2_read == $past(port2_pins_in, 3)) // R4
      else $error("port read wrong");
   rise_irq_a: assert property (@(posedge mclk) disable iff (rst)
      ext_irq_two |-> $past(lvl1[QBP_P1_IRQ2]) && !$past(lvl1_d[QBP_P1_IRQ2])) // R6
      else $error("irq two without rising edge");
   addr_hi_a: assert property (@(posedge mclk) disable iff (rst)
      ext_bus_active && !page_mode1 |=> port2_pins_pd == ~$past(ext_addr[15:8])) // R7
      else $error("address high byte absent");
   gate_a: assert property (@(posedge mclk) disable iff (rst)
      !latch_p3[QBP_P3_U0TX] |=> port3_pins_pd[QBP_P3_U0TX]) // R15
      else $error("alternate passed zero latch");
   source_a: assert property (@(posedge mclk) disable iff (rst)
      !program_source_sel |=> fetch_external) // R13
      else $error("external fetch not selected");
   cov_kick_c: cover property (@(posedge mclk) port1_pins_pu[0]);
   cov_irq_c: cover property (@(posedge mclk) ext_irq_five);
   cov_page_c: cover property (@(posedge mclk) ext_bus_active && page_mode1);
endmodule : qbp_ports

//--- tb_qbp_ports.sv
`timescale 1ns/1ps
module tb_qbp_ports;
   import qbp_pkg::*;
   logic        mclk, rst, wr1, wr2, wr3, t2o, u1tx, u0tx, wrs_n, rds_n, bus, pg1, lowph;
   logic        sel, ireq, t2io, t2tr, u1rx, u0rx, i2, i3, i4, i5, i0, i1, tz, to, fx, iok;
   logic [7:0]  wdata, low1, low2, low3, p1i, p2i, p3i, pd1, pu1, pd2, pu2, pd3, pu3;
   logic [7:0]  rd1, rd2, rd3, l1, l2, l3;
   logic [15:0] addr;
   int          mismatches, check_count, n2, n3, n4, n5, k;
   qbp_ports dut (.mclk(mclk), .rst(rst), .latch_wr_p1(wr1), .latch_wr_p2(wr2),
      .latch_wr_p3(wr3), .latch_wdata(wdata), .port1_pins_in(p1i), .port2_pins_in(p2i),
      .port3_pins_in(p3i), .timer_two_io_out(t2o), .uart1_tx_out(u1tx), .uart0_tx_out(u0tx),
      .xdata_wr_strobe_n(wrs_n), .xdata_rd_strobe_n(rds_n), .ext_bus_active(bus),
      .page_mode1(pg1), .ext_addr(addr), .addr_low_phase(lowph), .program_source_sel(sel),
      .iram_access_req(ireq), .port1_pins_pd(pd1), .port1_pins_pu(pu1), .port2_pins_pd(pd2),
      .port2_pins_pu(pu2), .port3_pins_pd(pd3), .port3_pins_pu(pu3), .port1_read(rd1),
      .port2_read(rd2), .port3_read(rd3), .latch_p1(l1), .latch_p2(l2), .latch_p3(l3),
      .timer_two_io(t2io), .timer_two_trigger(t2tr), .uart1_rx_in(u1rx), .uart0_rx_in(u0rx),
      .ext_irq_two(i2), .ext_irq_three(i3), .ext_irq_four(i4), .ext_irq_five(i5),
      .ext_irq_zero_lvl(i0), .ext_irq_one(i1), .timer_zero_count_in(tz),
      .timer_one_count_in(to), .fetch_external(fx), .iram_access_ok(iok));
   qbp_ext_model ext (.port1_pins_pd(pd1), .port2_pins_pd(pd2), .port3_pins_pd(pd3),
      .pull_low1(low1), .pull_low2(low2), .pull_low3(low3), .port1_pins_in(p1i),
      .port2_pins_in(p2i), .port3_pins_in(p3i));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // pulses are one cycle wide, so count them once per cycle
   always @(negedge mclk) begin
      n2 = n2 + int'(i2 === 1'b1);
      n3 = n3 + int'(i3 === 1'b1);
      n4 = n4 + int'(i4 === 1'b1);
      n5 = n5 + int'(i5 === 1'b1);
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask : cyc
   task automatic wr(input int p, input logic [7:0] d);
      wdata = d;
      wr1 = (p == 1);
      wr2 = (p == 2);
      wr3 = (p == 3);
      cyc(1);
      {wr1, wr2, wr3} = 3'h0;
   endtask : wr
   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : summarize
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_drive;
      wr(1, 8'h00);
      cyc(5);
      chk({l1, pd1}, 16'h00ff, "latch zero pulldown");
      chk(rd1, 8'h00, "pulled low readback");
      cyc(20);
      chk({pd1, pu1}, 16'hff00, "pulldown held");
      wr(1, 8'hff);
      k = 0;
      repeat (8) begin
         cyc(1);
         k = k + int'(pu1 === 8'hff);
      end
      chk(16'(k), 16'(QBP_KICK_CYC), "kick length");
      chk({pd1, pu1}, 16'h0000, "weak pullup only");
      wr(2, 8'h5a);
      cyc(3);
      chk(pd2, 8'ha5, "port 2 per-bit pulldown");
      cyc(2);
      chk(rd2, 8'h5a, "port 2 readback");
      wr(2, 8'hff);
   endtask : t_drive
   task automatic t_inputs;
      {n2, n3, n4, n5} = '0;
      low1 = 8'hf5;
      low3 = 8'h3d;
      cyc(6);
      chk({n2[3:0], n3[3:0], n4[3:0], n5[3:0]}, 16'h0101, "falling edge pulses");
      chk({rd1, rd3}, 16'h0ac2, "inputs read");
      chk({t2io, t2tr, u1rx, u0rx}, 16'h4, "port rx inputs");
      chk({i0, i1, tz, to}, 16'h0, "port 3 inputs");
      low1 = 8'h00;
      low3 = 8'h00;
      cyc(6);
      chk({n2[3:0], n3[3:0], n4[3:0], n5[3:0]}, 16'h1111, "rising edge pulses");
      chk({t2io, u0rx, i0, i1, tz, to}, 16'h3f, "inputs released");
   endtask : t_inputs
   task automatic t_alt;
      {t2o, u1tx, u0tx, wrs_n, rds_n} = 5'h0;
      cyc(3);
      chk({pd1, pd3}, 16'h09c2, "alternate outputs drive");
      wr(3, 8'h7d);
      {t2o, u1tx, u0tx, wrs_n, rds_n} = 5'h1f;
      cyc(3);
      chk(pd3, 8'h82, "latch zero wins");
      wr(3, 8'hff);
   endtask : t_alt
   task automatic t_bus;
      addr = 16'h12a5;
      bus = 1'b1;
      cyc(3);
      chk(pd2, 8'hed, "address high byte");
      {pg1, lowph} = 2'b11;
      cyc(3);
      chk(pd2, 8'h5a, "page mode low byte");
      lowph = 1'b0;
      cyc(3);
      chk(pd2, 8'hed, "page mode high byte");
      {bus, pg1} = 2'b00;
   endtask : t_bus
   task automatic t_strap;
      sel = 1'b0;
      ireq = 1'b1;
      cyc(2);
      chk({fx, iok}, 16'h3, "external fetch, ram kept");
      sel = 1'b1;
      ireq = 1'b0;
      cyc(2);
      chk({fx, iok}, 16'h0, "internal fetch");
   endtask : t_strap
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {rst, wr1, wr2, wr3, bus, pg1, lowph, ireq} = 8'hff;
      {wr1, wr2, wr3, bus, pg1, lowph, ireq} = 7'h0;
      {t2o, u1tx, u0tx, wrs_n, rds_n, sel} = 6'h3f;
      {wdata, low1, low2, low3, addr} = '0;
      {mismatches, check_count, n2, n3, n4, n5} = '0;
      cyc(10);
      rst = 1'b0;
      cyc(1);
      chk({l1, l2}, 16'hffff, "reset latches");
      chk({l3, pd1 | pd2 | pd3}, 16'hff00, "reset drive");
      chk({rd1, pu1 | pu2 | pu3}, 16'hff00, "reset read");
      chk(fx, 1'b0, "reset fetch select");
      t_drive();
      t_inputs();
      t_alt();
      t_bus();
      t_strap();
      summarize();
   end
   // no test needs more than a few hundred cycles
   initial begin
      repeat (5000) @(posedge mclk);
      mismatches++;
      summarize();
   end
endmodule : tb_qbp_ports
